// >>> dv/bms_sensor_model.sv
// sensing element front end: answers each sample request after a short delay
`timescale 1ns/1ps
module bms_sensor_model (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // request side
  input wire logic conv_start,
  input wire logic conv_temp,
  input wire logic [23:0] base,
  // sample side
  output logic adc_valid,
  output logic [23:0] adc_data
);
  logic [2:0] wcnt;
  logic [3:0] cnt;
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      wcnt <= 3'h0;
      cnt <= 4'h0;
      adc_valid <= 1'b0;
      adc_data <= 24'h5A5A5A;
    end else begin
      adc_valid <= 1'b0;
      adc_data <= ~adc_data; // a stale sample outside the strobe would hide a missed one
      if (conv_start) begin
        wcnt <= {1'b0, cnt[1:0]} + 3'h1; // delay moves between prompt and slow
      end else if (wcnt == 3'h1) begin
        wcnt <= 3'h0;
        adc_valid <= 1'b1;
        adc_data <= base + (conv_temp ? 24'h001000 : 24'h000000) + {19'h0, cnt, 1'b0};
        cnt <= cnt + 4'h1;
      end else if (wcnt != 3'h0) begin
        wcnt <= wcnt - 3'h1;
      end
    end
  end
endmodule : bms_sensor_model

// >>> dv/bms_sequencer_props.sv
// assertions on the measurement sequencer ports
`timescale 1ns/1ps
module bms_sequencer_props (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // controls
  input wire logic mode_wr,
  input wire bms_pkg::bms_mode_t mode_wdata,
  input wire bms_pkg::bms_operating_mode_status_reg_t pressure_config_reg,
  input wire bms_pkg::bms_int_cfg_t int_queue_cfg,
  input wire logic csb_n_pin,
  // sensor side
  input wire logic adc_valid,
  input wire logic [23:0] adc_data,
  input wire logic conv_start,
  input wire logic conv_temp,
  // state and pin
  input wire bms_pkg::bms_mode_t operating_mode_status_reg,
  input wire logic [23:0] pressure_result_bytes,
  input wire bms_pkg::bms_queue_sts_t queue_status_reg,
  input wire logic [2:0] interrupt_status_reg,
  input wire logic spi_sel,
  input wire logic addr_irq_pin_o,
  input wire logic addr_irq_pin_oe_n
);
  import bms_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // mode shows up one cycle after the write, the first sample request one cycle later
  sequence cmd_launch_s;
    (operating_mode_status_reg == $past(mode_wdata)) ##1 conv_start;
  endsequence
  cmd_launch_a: assert property (mode_wr && operating_mode_status_reg == BMS_MODE_STANDBY &&
    (mode_wdata == BMS_MODE_CMD_PRS || mode_wdata == BMS_MODE_CMD_TMP) |=> cmd_launch_s)
    else $error("command write did not start a conversion");
  standby_quiet_a: assert property (conv_start |-> $past(operating_mode_status_reg) != BMS_MODE_STANDBY)
    else $error("conversion requested in standby");
  cmd_result_a: assert property (operating_mode_status_reg == BMS_MODE_CMD_PRS && adc_valid && !mode_wr &&
    pressure_config_reg.prc == 3'h0 && !int_queue_cfg.fifo_en |=> operating_mode_status_reg == BMS_MODE_STANDBY
    && pressure_result_bytes == $past(adc_data))
    else $error("single sample command did not store and return to standby");
  temp_conv_a: assert property (operating_mode_status_reg == BMS_MODE_CMD_TMP && conv_start |-> conv_temp)
    else $error("temperature command sampled as pressure");
  full_irq_a: assert property ($rose(queue_status_reg.full) && int_queue_cfg.int_fifo_en |-> ##[0:2] interrupt_status_reg[2])
    else $error("queue full not flagged in interrupt status");
  empty_value_a: assert property (int_queue_cfg.fifo_en && queue_status_reg.empty && $past(queue_status_reg.empty) &&
    $changed(pressure_result_bytes) |-> pressure_result_bytes == 24'h800000)
    else $error("drained queue returned a value other than empty marker");
  spi_latch_a: assert property ($fell(csb_n_pin) |-> ##[1:5] spi_sel)
    else $error("low chip select did not select spi");
  spi_hold_a: assert property (spi_sel |=> spi_sel)
    else $error("spi selection dropped without reset");
  no_irq_4wire_a: assert property ((spi_sel && !int_queue_cfg.spi_3wire) [*3] |-> addr_irq_pin_oe_n)
    else $error("pin driven in four-wire spi");
  pin_level_a: assert property (!addr_irq_pin_oe_n && int_queue_cfg.int_fifo_en && interrupt_status_reg[2]
    ##1 $stable(int_queue_cfg) |-> addr_irq_pin_o == int_queue_cfg.int_active_high)
    else $error("interrupt pin not at active level");
endmodule : bms_sequencer_props

// >>> dv/tb_baro_measure_sequencer_fifo.sv
// testbench of the measurement sequencer with its result queue
`timescale 1ns/1ps
module tb_baro_measure_sequencer_fifo;
  import bms_pkg::*;
  logic mclk, link_clk, reset, mode_wr, adc_valid, conv_start, conv_temp, link_prs_rd, link_interrupt_status_reg_rd;
  logic csb_n_pin, spi_sel, addr_irq_pin_o, addr_irq_pin_oe_n, strap, rec;
  bms_mode_t mode_wdata, operating_mode_status_reg;
  bms_operating_mode_status_reg_t pressure_config_reg, temp_config_reg;
  bms_int_cfg_t int_queue_cfg;
  bms_queue_sts_t link_queue_sts, queue_status_reg;
  logic [23:0] adc_data, link_prs_data, pressure_result_bytes, temp_result_bytes, base, exp, lastp;
  logic [2:0] interrupt_status_reg, prc;
  logic [6:0] i2c_addr;
  logic [31:0] acc;
  logic [23:0] expq[$];
  wire addr_irq_pin_i;
  int failures, comparisons, seed, k;
  // pin level: strap resistor unless the device drives it
  assign addr_irq_pin_i = addr_irq_pin_oe_n ? strap : addr_irq_pin_o;
  bms_sequencer #(.RATE_BASE_CYC(20)) DUT (.mclk, .link_clk, .reset, .mode_wr, .mode_wdata,
    .pressure_config_reg, .temp_config_reg, .int_queue_cfg, .adc_valid, .adc_data, .conv_start, .conv_temp,
    .link_prs_rd, .link_interrupt_status_reg_rd, .link_prs_data, .link_queue_sts, .operating_mode_status_reg,
    .pressure_result_bytes, .temp_result_bytes, .queue_status_reg, .interrupt_status_reg, .csb_n_pin,
    .spi_sel, .i2c_addr, .addr_irq_pin_i, .addr_irq_pin_o, .addr_irq_pin_oe_n);
  bms_sensor_model u_sensor (.mclk, .reset, .conv_start, .conv_temp, .base, .adc_valid, .adc_data);
  always #20 mclk = ~mclk;
  initial begin
    link_clk = 1'b0;
    #7;
    forever #80 link_clk = ~link_clk;
  end
  always @(posedge mclk) begin
    if (mode_wr) acc <= 32'h0;
    else if (adc_valid) acc <= acc + {8'h00, adc_data};
    if (rec && adc_valid && expq.size() < 32) expq.push_back({adc_data[23:1], ~conv_temp});
  end
  // ----------------------------------------
  // checking and waiting
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expv);
    comparisons++;
    if (seen !== expv) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, expv, seen);
    end
  endtask : check
  task automatic conclude();
    if (failures == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude
  task automatic wait_until(input bit full_wait, input int n);
    int i;
    for (i = 0; i < n; i++) begin
      @(posedge mclk);
      #1;
      if (full_wait ? queue_status_reg.full === 1'b1 : operating_mode_status_reg === BMS_MODE_STANDBY) break;
    end
    if (i == n) begin
      failures++;
      conclude();
    end
  endtask : wait_until
  task automatic write_mode(input bms_mode_t m);
    @(posedge mclk);
    mode_wr <= 1'b1;
    mode_wdata <= m;
    @(posedge mclk);
    mode_wr <= 1'b0;
  endtask : write_mode
  // host reads cross from the link domain in a few mclk cycles
  task automatic pop();
    @(posedge link_clk);
    link_prs_rd <= 1'b1;
    @(posedge link_clk);
    link_prs_rd <= 1'b0;
    repeat (8) @(posedge mclk);
    #1;
  endtask : pop
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {mclk, mode_wr, link_prs_rd, link_interrupt_status_reg_rd, rec} = 5'h00;
    {reset, csb_n_pin, strap} = 3'h7;
    mode_wdata = BMS_MODE_STANDBY;
    {pressure_config_reg, temp_config_reg, int_queue_cfg} = 18'h00000;
    {base, lastp} = 48'h0;
    seed = 16;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    check("mode", operating_mode_status_reg, BMS_MODE_STANDBY);
    check("queue sts", queue_status_reg, 2'h1);
    check("i2c addr", i2c_addr, 7'h77);
    check("spi sel", spi_sel, 1'b0);
    for (k = 0; k < 8; k++) begin
      prc = (k < 2) ? 3'h0 : 3'($random(seed) & 3);
      @(posedge mclk);
      base <= 24'($random(seed)) & 24'h0FFFF0;
      pressure_config_reg <= {3'h7, prc};
      temp_config_reg <= {3'h7, prc};
      write_mode(k[0] ? BMS_MODE_CMD_TMP : BMS_MODE_CMD_PRS);
      wait_until(1'b0, 500);
      exp = 24'(acc >> prc);
      if (!k[0]) lastp = exp;
      check("result", k[0] ? temp_result_bytes : pressure_result_bytes, exp);
      check("interrupt_status_reg", interrupt_status_reg[k[0]], 1'b1);
      pop();
      check("prs kept", pressure_result_bytes, lastp);
    end
    @(posedge mclk);
    reset <= 1'b1;
    strap <= 1'b0;
    pressure_config_reg <= 6'h38; // fastest rate, single sample keeps both within budget
    temp_config_reg <= 6'h38;
    int_queue_cfg <= 6'h32; // strap low, so active high
    rec <= 1'b1;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    check("i2c addr", i2c_addr, 7'h76);
    write_mode(BMS_MODE_BG_BOTH);
    wait_until(1'b1, 3000);
    repeat (100) @(posedge mclk);
    #1;
    check("fifo int", interrupt_status_reg[2], 1'b1);
    check("irq pin", addr_irq_pin_i, 1'b1);
    check("recorded", expq.size(), 32);
    write_mode(BMS_MODE_STANDBY);
    repeat (20) @(posedge mclk);
    for (k = 0; k < 32; k++) begin
      pop();
      check("entry", pressure_result_bytes, expq[k]);
      if (k == 0) check("full", queue_status_reg.full, 1'b0);
    end
    pop();
    check("empty val", pressure_result_bytes, 24'h800000);
    check("empty", queue_status_reg.empty, 1'b1);
    pop();
    check("empty again", pressure_result_bytes, 24'h800000);
    repeat (5) @(posedge link_clk);
    #1;
    check("link data", link_prs_data, 24'h800000);
    check("link sts", link_queue_sts, 2'h1);
    @(posedge link_clk);
    link_interrupt_status_reg_rd <= 1'b1;
    @(posedge link_clk);
    link_interrupt_status_reg_rd <= 1'b0;
    repeat (8) @(posedge mclk);
    #1;
    check("fifo int clr", interrupt_status_reg[2], 1'b0);
    check("irq pin idle", addr_irq_pin_i, 1'b0);
    @(posedge mclk);
    csb_n_pin <= 1'b0;
    repeat (8) @(posedge mclk);
    #1;
    check("spi sel", spi_sel, 1'b1);
    check("pin released", addr_irq_pin_oe_n, 1'b1);
    @(posedge mclk);
    csb_n_pin <= 1'b1;
    int_queue_cfg <= 6'h33;
    repeat (4) @(posedge mclk);
    #1;
    check("pin 3wire", addr_irq_pin_oe_n, 1'b0);
    write_mode(BMS_MODE_BG_TMP);
    repeat (30) @(posedge mclk);
    write_mode(BMS_MODE_STANDBY);
    pop();
    check("tmp tag", pressure_result_bytes[0], 1'b0);
    conclude();
  end
endmodule : tb_baro_measure_sequencer_fifo
bind bms_sequencer bms_sequencer_props u_props (.mclk, .reset, .mode_wr, .mode_wdata, .pressure_config_reg,
  .int_queue_cfg, .csb_n_pin, .adc_valid, .adc_data, .conv_start, .conv_temp, .operating_mode_status_reg,
  .pressure_result_bytes, .queue_status_reg, .interrupt_status_reg, .spi_sel, .addr_irq_pin_o,
  .addr_irq_pin_oe_n);

// >>> rtl/bms_sequencer.sv
// measurement sequencer, result registers, result queue and host port selection
// Functional notes
// - reset leaves the device in standby with no conversion running
// - in standby all results and configuration stay readable and writable
// - command mode does one conversion, stores it, then drops back to standby
// - background repeats conversions at set rate; in both-measurement mode a due temperature follows pressure immediately
// - background results can be buffered in a 32-entry queue
// - higher precision oversamples the sensor and merges samples into one result
// - host port is i2c until a low chip select is seen, then spi
// - i2c address is 0x77, or 0x76 when the address pin is strapped low
// - spi is four-wire unless the three-wire configuration bit is set
// - interrupt on new result, on queue full, or both, via address pin
// - no interrupt signalling while the port is four-wire spi
// - interrupt causes are kept in a readable interrupt status register
// - latest pressure and temperature held separately; temperature may be disabled
// - queue off: reads leave results unchanged; only new conversions update them
// - queue on: each pressure read advances; drained queue reads 0x800000
// - empty flag set when nothing is left; later reads keep returning 0x800000
// - queued 24-bit entries carry type in bit 0: pressure 1, temperature 0
// - queued entries always appear through the pressure result bytes
// - full queue sets full flag and interrupts when full interrupt enabled
// - full queue discards new results instead of overwriting entries
`timescale 1ns/1ps
`include "bms_map.svh"

module bms_sequencer #(
  parameter int unsigned RATE_BASE_CYC = `BMS_RATE_BASE_CYC
) (
  // clocks and reset
  input wire logic mclk,
  input wire logic link_clk,
  input wire logic reset,
  // operating mode register write
  input wire logic mode_wr,
  input wire bms_pkg::bms_mode_t mode_wdata,
  // measurement and interrupt/queue configuration
  input wire bms_pkg::bms_operating_mode_status_reg_t pressure_config_reg,
  input wire bms_pkg::bms_operating_mode_status_reg_t temp_config_reg,
  input wire bms_pkg::bms_int_cfg_t int_queue_cfg,
  // sensing element front end (mclk domain)
  input wire logic adc_valid,
  input wire logic [23:0] adc_data,
  output logic conv_start,
  output logic conv_temp,
  // host read events and data (link clock domain)
  input wire logic link_prs_rd,
  input wire logic link_interrupt_status_reg_rd,
  output logic [23:0] link_prs_data,
  output bms_pkg::bms_queue_sts_t link_queue_sts,
  // state seen by the register file (mclk domain)
  output bms_pkg::bms_mode_t operating_mode_status_reg,
  output logic [23:0] pressure_result_bytes,
  output logic [23:0] temp_result_bytes,
  output bms_pkg::bms_queue_sts_t queue_status_reg,
  output logic [2:0] interrupt_status_reg,
  // host port selection pins and status
  input wire logic csb_n_pin,
  output logic spi_sel,
  output logic [6:0] i2c_addr,
  // address/interrupt pin
  input wire logic addr_irq_pin_i,
  output logic addr_irq_pin_o,
  output logic addr_irq_pin_oe_n
);
  import bms_pkg::*;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  bms_state_t state_reg, state_next;
  bms_mode_t mode_reg, mode_next;
  logic temp_reg, temp_next;
  logic start_reg, start_next;
  logic [7:0] osr_left_reg, osr_left_next;
  logic signed [30:0] acc_reg, acc_next;
  logic [31:0] prs_tmr_reg, prs_tmr_next;
  logic [31:0] tmp_tmr_reg, tmp_tmr_next;
  logic prs_pend_reg, prs_pend_next;
  logic tmp_pend_reg, tmp_pend_next;
  logic [23:0] prs_res_reg, prs_res_next;
  logic [23:0] tmp_res_reg, tmp_res_next;
  logic [2:0] interrupt_status_reg_reg, interrupt_status_reg_next;
  logic upd_tgl_reg, upd_tgl_next;
  logic [5:0] count_reg, count_next;
  logic [4:0] wptr_reg, wptr_next;
  logic [4:0] rptr_reg, rptr_next;
  bms_queue_sts_t qsts_reg, qsts_next;
  logic [23:0] mem_reg [0:31];
  logic push;
  logic [23:0] push_data;
  logic signed [30:0] acc_sum;
  logic signed [30:0] avg;
  logic [2:0] cur_prc;
  logic bg_mode;
  // crossings into mclk
  logic pop_s1, pop_s2, pop_s3;
  logic clr_s1, clr_s2, clr_s3;
  logic csb_s1, csb_s2;
  logic addr_s1, addr_s2;
  logic pop_ev, clr_ev;
  // pin control
  logic spi_reg, spi_next;
  logic [1:0] strap_cnt_reg, strap_cnt_next;
  logic [6:0] addr_reg, addr_next;
  logic irq_o_reg, irq_o_next;
  logic irq_oe_n_reg, irq_oe_n_next;
  // link domain
  logic pop_tgl_reg, pop_tgl_next;
  logic clr_tgl_reg, clr_tgl_next;
  logic upd_l1, upd_l2, upd_l3;
  bms_queue_sts_t qs_l1, qs_l2;
  logic [23:0] ldata_reg, ldata_next;

  function automatic logic [31:0] rate_interval(input logic [2:0] rate);
    rate_interval = RATE_BASE_CYC[31:0] << (`BMS_RATE_MAX_CODE - rate);
  endfunction : rate_interval

  // ----------------------------------------
  // synchronisers into mclk
  // ----------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pop_s1 <= 1'b0;
      pop_s2 <= 1'b0;
      pop_s3 <= 1'b0;
      clr_s1 <= 1'b0;
      clr_s2 <= 1'b0;
      clr_s3 <= 1'b0;
      csb_s1 <= 1'b1;
      csb_s2 <= 1'b1;
      addr_s1 <= 1'b1;
      addr_s2 <= 1'b1;
    end else begin
      pop_s1 <= pop_tgl_reg;
      pop_s2 <= pop_s1;
      pop_s3 <= pop_s2;
      clr_s1 <= clr_tgl_reg;
      clr_s2 <= clr_s1;
      clr_s3 <= clr_s2;
      csb_s1 <= csb_n_pin;
      csb_s2 <= csb_s1;
      addr_s1 <= addr_irq_pin_i;
      addr_s2 <= addr_s1;
    end
  end

  assign pop_ev = pop_s2 ^ pop_s3;
  assign clr_ev = clr_s2 ^ clr_s3;

  // ----------------------------------------
  // sequencer, result registers and queue control
  // ----------------------------------------
  assign bg_mode = mode_reg[2];
  assign cur_prc = temp_reg ? temp_config_reg.prc : pressure_config_reg.prc;
  assign acc_sum = acc_reg + {{7{adc_data[23]}}, adc_data};
  assign avg = acc_sum >>> cur_prc;

  always_comb begin
    state_next = state_reg;
    mode_next = mode_reg;
    temp_next = temp_reg;
    start_next = 1'b0;
    osr_left_next = osr_left_reg;
    acc_next = acc_reg;
    prs_tmr_next = prs_tmr_reg;
    tmp_tmr_next = tmp_tmr_reg;
    prs_pend_next = prs_pend_reg;
    tmp_pend_next = tmp_pend_reg;
    prs_res_next = prs_res_reg;
    tmp_res_next = tmp_res_reg;
    // a host read clears the causes seen so far; a cause arriving in the same cycle sets again
    interrupt_status_reg_next = clr_ev ? `BMS_INTERRUPT_STATUS_REG_RST : interrupt_status_reg_reg;
    upd_tgl_next = upd_tgl_reg;
    count_next = count_reg;
    wptr_next = wptr_reg;
    rptr_next = rptr_reg;
    push = 1'b0;
    push_data = {avg[23:1], temp_reg ? `BMS_TAG_TMP : `BMS_TAG_PRS};
    // rate timers run only in background; each expiry requests one conversion if the mode enables that measurement
    if (bg_mode) begin
      prs_tmr_next = (prs_tmr_reg == 32'h00000000) ? rate_interval(pressure_config_reg.rate) : prs_tmr_reg - 32'h1;
      tmp_tmr_next = (tmp_tmr_reg == 32'h00000000) ? rate_interval(temp_config_reg.rate) : tmp_tmr_reg - 32'h1;
      if (prs_tmr_reg == 32'h00000000 && mode_reg[0]) begin
        prs_pend_next = 1'b1;
      end
      if (tmp_tmr_reg == 32'h00000000 && mode_reg[1]) begin
        tmp_pend_next = 1'b1;
      end
    end else begin
      prs_tmr_next = 32'h00000000;
      tmp_tmr_next = 32'h00000000;
      prs_pend_next = 1'b0;
      tmp_pend_next = 1'b0;
    end
    if (mode_wr) begin
      mode_next = mode_wdata;
    end
    case (state_reg)
      BMS_ST_IDLE: begin
        if (mode_reg == BMS_MODE_CMD_PRS || mode_reg == BMS_MODE_CMD_TMP) begin
          temp_next = (mode_reg == BMS_MODE_CMD_TMP);
          state_next = BMS_ST_SAMPLE;
        end else if (bg_mode && prs_pend_reg) begin
          temp_next = 1'b0;
          prs_pend_next = 1'b0;
          state_next = BMS_ST_SAMPLE;
        end else if (bg_mode && tmp_pend_reg) begin
          temp_next = 1'b1;
          tmp_pend_next = 1'b0;
          state_next = BMS_ST_SAMPLE;
        end
        if (state_next == BMS_ST_SAMPLE) begin
          start_next = 1'b1;
          acc_next = 31'sh00000000;
          osr_left_next = 8'h01 << (temp_next ? temp_config_reg.prc : pressure_config_reg.prc);
        end
      end
      BMS_ST_SAMPLE: begin
        if (mode_wr && mode_wdata == BMS_MODE_STANDBY) begin
          state_next = BMS_ST_IDLE;
        end else if (adc_valid) begin
          acc_next = acc_sum;
          osr_left_next = osr_left_reg - 8'h01;
          if (osr_left_reg != 8'h01) begin
            start_next = 1'b1;
          end else begin
            state_next = BMS_ST_IDLE;
            interrupt_status_reg_next[temp_reg ? `BMS_INT_TMP_BIT : `BMS_INT_PRS_BIT] = 1'b1;
            if (int_queue_cfg.fifo_en) begin
              push = (count_reg != `BMS_QUEUE_DEPTH);
            end else if (temp_reg) begin
              tmp_res_next = avg[23:0];
            end else begin
              prs_res_next = avg[23:0];
              upd_tgl_next = ~upd_tgl_reg;
            end
            if (!bg_mode) begin
              mode_next = BMS_MODE_STANDBY;
            end else if (!temp_reg && mode_reg == BMS_MODE_BG_BOTH && (tmp_pend_reg || tmp_pend_next)) begin
              temp_next = 1'b1;
              tmp_pend_next = 1'b0;
              start_next = 1'b1;
              acc_next = 31'sh00000000;
              osr_left_next = 8'h01 << temp_config_reg.prc;
              state_next = BMS_ST_SAMPLE;
            end
          end
        end
      end
      default: begin
        state_next = BMS_ST_IDLE;
      end
    endcase
    // queue pop on each host read of the pressure result
    if (pop_ev && int_queue_cfg.fifo_en) begin
      upd_tgl_next = ~upd_tgl_next;
      if (count_reg != 6'h00) begin
        prs_res_next = mem_reg[rptr_reg];
        rptr_next = rptr_reg + 5'h01;
      end else begin
        prs_res_next = `BMS_QUEUE_EMPTY_VAL;
      end
    end
    if (push) begin
      wptr_next = wptr_reg + 5'h01;
    end
    count_next = count_reg + {5'h00, push} - {5'h00, pop_ev && int_queue_cfg.fifo_en && count_reg != 6'h00};
    if (push && count_next == `BMS_QUEUE_DEPTH) begin
      interrupt_status_reg_next[`BMS_INT_FIFO_BIT] = 1'b1;
    end
    qsts_next.full = (count_next == `BMS_QUEUE_DEPTH);
    qsts_next.empty = (count_next == 6'h00);
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_reg <= BMS_ST_IDLE;
      mode_reg <= BMS_MODE_STANDBY;
      temp_reg <= 1'b0;
      start_reg <= 1'b0;
      osr_left_reg <= 8'h00;
      acc_reg <= 31'sh00000000;
      prs_tmr_reg <= 32'h00000000;
      tmp_tmr_reg <= 32'h00000000;
      prs_pend_reg <= 1'b0;
      tmp_pend_reg <= 1'b0;
      prs_res_reg <= `BMS_RESULT_RST;
      tmp_res_reg <= `BMS_RESULT_RST;
      interrupt_status_reg_reg <= `BMS_INTERRUPT_STATUS_REG_RST;
      upd_tgl_reg <= 1'b0;
      count_reg <= 6'h00;
      wptr_reg <= 5'h00;
      rptr_reg <= 5'h00;
      qsts_reg <= 2'b01;
    end else begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      temp_reg <= temp_next;
      start_reg <= start_next;
      osr_left_reg <= osr_left_next;
      acc_reg <= acc_next;
      prs_tmr_reg <= prs_tmr_next;
      tmp_tmr_reg <= tmp_tmr_next;
      prs_pend_reg <= prs_pend_next;
      tmp_pend_reg <= tmp_pend_next;
      prs_res_reg <= prs_res_next;
      tmp_res_reg <= tmp_res_next;
      interrupt_status_reg_reg <= interrupt_status_reg_next;
      upd_tgl_reg <= upd_tgl_next;
      count_reg <= count_next;
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      qsts_reg <= qsts_next;
    end
  end

  // ----------------------------------------
  // queue storage, one entry per generate step
  // ----------------------------------------
  for (genvar i = 0; i < 32; i++) begin : g_entry
    logic [23:0] entry_next;
    always_comb begin
      entry_next = (push && wptr_reg == 5'(i)) ? push_data : mem_reg[i];
    end
    always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
        mem_reg[i] <= `BMS_RESULT_RST;
      end else begin
        mem_reg[i] <= entry_next;
      end
    end
  end

  // ----------------------------------------
  // host port selection and address/interrupt pin
  // ----------------------------------------
  always_comb begin
    spi_next = spi_reg | ~csb_s2;
    strap_cnt_next = (strap_cnt_reg == 2'h3) ? strap_cnt_reg : strap_cnt_reg + 2'h1;
    addr_next = addr_reg;
    // strap is caught once the synchroniser holds the pin, before the pin can be driven as an interrupt
    if (strap_cnt_reg == 2'h2) begin
      addr_next = addr_s2 ? `BMS_I2C_ADDR_DEF : `BMS_I2C_ADDR_ALT;
    end
    irq_o_next = int_queue_cfg.int_active_high ~^ |(interrupt_status_reg_reg & {int_queue_cfg.int_fifo_en,
      int_queue_cfg.int_tmp_en, int_queue_cfg.int_prs_en});
    // four-wire spi owns the pin as data out, so interrupts stay off it
    irq_oe_n_next = ~(strap_cnt_reg == 2'h3 && (!spi_reg || int_queue_cfg.spi_3wire) &&
      (int_queue_cfg.int_fifo_en || int_queue_cfg.int_tmp_en || int_queue_cfg.int_prs_en));
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      spi_reg <= 1'b0;
      strap_cnt_reg <= 2'h0;
      addr_reg <= `BMS_I2C_ADDR_DEF;
      irq_o_reg <= 1'b0;
      irq_oe_n_reg <= 1'b1;
    end else begin
      spi_reg <= spi_next;
      strap_cnt_reg <= strap_cnt_next;
      addr_reg <= addr_next;
      irq_o_reg <= irq_o_next;
      irq_oe_n_reg <= irq_oe_n_next;
    end
  end

  // ----------------------------------------
  // link clock side: read events out, result word in
  // ----------------------------------------
  // the result word is sampled only after its toggle has crossed, so it has been stable two link edges
  always_comb begin
    pop_tgl_next = pop_tgl_reg ^ link_prs_rd;
    clr_tgl_next = clr_tgl_reg ^ link_interrupt_status_reg_rd;
    ldata_next = (upd_l2 ^ upd_l3) ? prs_res_reg : ldata_reg;
  end

  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      pop_tgl_reg <= 1'b0;
      clr_tgl_reg <= 1'b0;
      upd_l1 <= 1'b0;
      upd_l2 <= 1'b0;
      upd_l3 <= 1'b0;
      qs_l1 <= 2'b01;
      qs_l2 <= 2'b01;
      ldata_reg <= `BMS_RESULT_RST;
    end else begin
      pop_tgl_reg <= pop_tgl_next;
      clr_tgl_reg <= clr_tgl_next;
      upd_l1 <= upd_tgl_reg;
      upd_l2 <= upd_l1;
      upd_l3 <= upd_l2;
      qs_l1 <= qsts_reg;
      qs_l2 <= qs_l1;
      ldata_reg <= ldata_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign conv_start = start_reg;
  assign conv_temp = temp_reg;
  assign link_prs_data = ldata_reg;
  assign link_queue_sts = qs_l2;
  assign operating_mode_status_reg = mode_reg;
  assign pressure_result_bytes = prs_res_reg;
  assign temp_result_bytes = tmp_res_reg;
  assign queue_status_reg = qsts_reg;
  assign interrupt_status_reg = interrupt_status_reg_reg;
  assign spi_sel = spi_reg;
  assign i2c_addr = addr_reg;
  assign addr_irq_pin_o = irq_o_reg;
  assign addr_irq_pin_oe_n = irq_oe_n_reg;

endmodule : bms_sequencer

// >>> shared/bms_map.svh
// constants of the barometer measurement sequencer: codes, fields, timing
`ifndef BMS_MAP_SVH
`define BMS_MAP_SVH

// ----------------------------------------
// operating mode codes
// ----------------------------------------
`define BMS_MODE_STANDBY 3'h0
`define BMS_MODE_CMD_PRS 3'h1
`define BMS_MODE_CMD_TMP 3'h2
`define BMS_MODE_BG_PRS 3'h5
`define BMS_MODE_BG_TMP 3'h6
`define BMS_MODE_BG_BOTH 3'h7

// ----------------------------------------
// serial port addressing
// ----------------------------------------
`define BMS_I2C_ADDR_DEF 7'h77
`define BMS_I2C_ADDR_ALT 7'h76

// ----------------------------------------
// result queue
// ----------------------------------------
`define BMS_QUEUE_DEPTH 6'h20
`define BMS_QUEUE_EMPTY_VAL 24'h800000
`define BMS_TAG_PRS 1'h1
`define BMS_TAG_TMP 1'h0

// ----------------------------------------
// interrupt status bit positions
// ----------------------------------------
`define BMS_INT_PRS_BIT 0
`define BMS_INT_TMP_BIT 1
`define BMS_INT_FIFO_BIT 2

// ----------------------------------------
// reset values
// ----------------------------------------
`define BMS_RESULT_RST 24'h000000
`define BMS_INTERRUPT_STATUS_REG_RST 3'h0

// ----------------------------------------
// timing: clock period and fastest-rate base interval (1/128 s)
// ----------------------------------------
`define BMS_MCLK_PERIOD_NS 40
`define BMS_RATE_BASE_NS 7812500
`define BMS_RATE_BASE_CYC (`BMS_RATE_BASE_NS / `BMS_MCLK_PERIOD_NS)
`define BMS_RATE_MAX_CODE 3'h7

`endif

// >>> shared/bms_pkg.sv
// types of the barometer measurement sequencer
package bms_pkg;

  typedef enum logic [2:0] {
    BMS_MODE_STANDBY = 3'h0,
    BMS_MODE_CMD_PRS = 3'h1,
    BMS_MODE_CMD_TMP = 3'h2,
    BMS_MODE_BG_PRS = 3'h5,
    BMS_MODE_BG_TMP = 3'h6,
    BMS_MODE_BG_BOTH = 3'h7
  } bms_mode_t;

  typedef enum logic [1:0] {
    BMS_ST_IDLE = 2'b00,
    BMS_ST_SAMPLE = 2'b01
  } bms_state_t;

  // precision (oversampling = 2**prc) and rate (2**rate per second)
  typedef struct packed {
    logic [2:0] rate;
    logic [2:0] prc;
  } bms_operating_mode_status_reg_t;

  typedef struct packed {
    logic int_active_high;
    logic int_fifo_en;
    logic int_tmp_en;
    logic int_prs_en;
    logic fifo_en;
    logic spi_3wire;
  } bms_int_cfg_t;

  typedef struct packed {
    logic full;
    logic empty;
  } bms_queue_sts_t;

endpackage : bms_pkg
